// ---- logic/aofpc_pkg.sv ----
// Package: constants, register map and carrier types for the ADC output-format block.
// Assumes 32-bit APB with each 8-bit register in the low byte of one aligned word.
package aofpc_pkg;
  // ****************************************
  // Register map (index = printed offset, byte address = 4 x index)
  // ****************************************
  localparam int AOFPC_NREG = 10;
  localparam int AOFPC_ADDR_W = 10;
  localparam int R_OFS_LO = 0;
  localparam int R_OFS_HI = 1;
  localparam int R_FRAME = 2;
  localparam int R_CAL = 3;
  localparam int R_PHASE = 4;
  localparam int R_PA_LO = 5;
  localparam int R_PA_HI = 6;
  localparam int R_PB_LO = 7;
  localparam int R_PB_HI = 8;
  localparam int R_DUAL = 9;
  localparam logic [7:0] AOFPC_IDX [AOFPC_NREG] =
    '{8'h66, 8'h67, 8'h68, 8'h6b, 8'h6d, 8'h74, 8'h75, 8'h76, 8'h77, 8'h79};
  localparam logic [7:0] AOFPC_RST [AOFPC_NREG] =
    '{8'h00, 8'h00, 8'h24, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] AOFPC_WMASK [AOFPC_NREG] =
    '{8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  // ****************************************
  // Field positions
  // ****************************************
  localparam int FRAME_INV_BIT = 3;
  localparam int FRAME_EN_BIT = 2;
  localparam int XLSB_EN_BIT = 1;
  localparam int XLSB_INV_BIT = 0;
  localparam int RECAL_BIT = 2;
  localparam int PLL_EN_BIT = 5;
  localparam int DLY_LSB = 1;
  localparam int DLY_W = 3;
  localparam int DUAL_BIT = 7;
  // ****************************************
  // Modes and tables
  // ****************************************
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_14 = 2'h1;
  localparam logic [1:0] RES_16 = 2'h2;
  localparam logic [1:0] RES_18 = 2'h3;
  localparam logic [2:0] TP_DOUBLE = 3'h1;
  localparam logic [3:0] AOFPC_DLY_CYC [8] =
    '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'he, 4'hf};
  localparam logic [15:0] AOFPC_MASK [4] = '{16'hfff0, 16'hfffc, 16'hffff, 16'hffff};
  localparam int SAMPLE_W = 18;
  localparam int SUM_W = 21;
  localparam logic signed [SUM_W-1:0] SAT_MAX = 21'sh01ffff;
  localparam logic signed [SUM_W-1:0] SAT_MIN = -21'sh020000;
  localparam logic [15:0] PAT_RST = 16'h0000;

  typedef struct packed {
    logic [15:0] offset;
    logic [15:0] pat_a;
    logic [15:0] pat_b;
    logic frame_inv;
    logic frame_en;
    logic xlsb_en;
    logic xlsb_inv;
    logic [2:0] test_sel;
    logic lvds;
    logic [1:0] res;
    logic decim;
  } aofpc_cfg_t;

  typedef struct packed {
    logic [15:0] data;
    logic [1:0] word_clock_out;
    logic [1:0] overrange_out;
    logic [1:0] extra_lsb_pin_one;
    logic [1:0] extra_lsb_pin_two;
    logic frame_oe;
    logic lsb_oe;
  } aofpc_link_out_t;
endpackage : aofpc_pkg

// ---- logic/aofpc_top.sv ----
// Register bank and output formatter: offset, clamp, test pattern, aux pairs, PLL controls.
// Assumes same-clock neighbour settings on sys_clk and converter samples on link_clk.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// R01: Signed 16-bit global offset added to samples
// R02: Offset step scales with output resolution
// R03: Frame pair inverted in LVDS when set
// R04: Frame pair driven only while enabled
// R05: Extra LSbs appended in 16-bit decimation
// R06: Extra LSb pair inverted in LVDS
// R07: Any recal bit change starts calibration
// R08: PLL clock enable bit gates PLL clock
// R09: Delay code maps to VCO cycles
// R10: PLL settings need PLL source and enable
// R11: Delay only without decimation
// R12: Software keeps unused pattern LSbs zero
// R13: Pattern A two bytes, reset zero
// R14: Pattern B two bytes, reset zero
// R15: Dual post-processing enable bit drives output
// R16: Software leaves factory bits at reset
// R17: Double pattern alternates A and B
// R18: Pattern top bits drive overrange, word clock
// R19: Offset sum clamps, never wraps
module aofpc_top
  import aofpc_pkg::*;
(
  // Clocks and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic link_clk,
  // APB slave
  input wire logic [aofpc_pkg::AOFPC_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Neighbouring settings
  input wire logic pll_source_sel,
  input wire logic pll_circuit_en,
  input wire logic decim_active,
  input wire logic lvds_mode,
  input wire logic [1:0] res_mode,
  input wire logic [2:0] test_pattern_sel,
  // PLL and post-processing controls
  output logic pll_recal_start,
  output logic pll_clk_enable,
  output logic [3:0] out_clock_vco_delay,
  output logic dual_postproc_enable,
  // Link side
  input wire logic signed [aofpc_pkg::SAMPLE_W-1:0] conv_sample,
  input wire logic conv_overrange,
  output aofpc_pkg::aofpc_link_out_t link_out
);
  import aofpc_pkg::*;

  // ****************************************
  // APB slave
  // ****************************************
  logic [7:0] regs [AOFPC_NREG];
  logic [AOFPC_NREG-1:0] hit;
  logic addr_ok;
  logic wr_go;
  logic [7:0] rd_byte;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  assign addr_ok = (paddr[1:0] == 2'h0);
  // Write lands only on the completing access edge
  assign wr_go = psel && penable && pready && pwrite && pstrb[0];

  genvar gi;
  generate
    for (gi = 0; gi < AOFPC_NREG; gi++)
    begin : g_reg
      logic [7:0] next_reg;
      assign hit[gi] = addr_ok && (paddr[AOFPC_ADDR_W-1:2] == AOFPC_IDX[gi]);
      always_comb
      begin
        next_reg = regs[gi];
        if (!reset_n)
          next_reg = AOFPC_RST[gi];
        // R13 R14 byte registers
        else if (wr_go && hit[gi])
          next_reg = pwdata[7:0] & AOFPC_WMASK[gi];
      end
      always_ff @(posedge sys_clk)
      begin
        regs[gi] <= next_reg;
      end
    end
  endgenerate

  always_comb
  begin
    rd_byte = 8'h00;
    for (int i = 0; i < AOFPC_NREG; i++)
    begin
      if (hit[i])
        rd_byte = regs[i];
    end
  end

  // No wait state: pready rises in the first access cycle, and every answer comes straight from a flop
  always_comb
  begin
    next_pready = reset_n && psel && !penable;
    next_pslverr = next_pready && (hit == '0);
    next_prdata = prdata;
    if (!reset_n)
      next_prdata = 32'h0000_0000;
    else if (psel && !penable)
      next_prdata = {24'h000000, rd_byte};
  end

  always_ff @(posedge sys_clk)
  begin
    pready <= next_pready;
    pslverr <= next_pslverr;
    prdata <= next_prdata;
  end

  // ****************************************
  // PLL and post-processing controls
  // ****************************************
  logic recal_prev;
  logic next_recal_prev;
  logic next_recal_start;
  logic next_pll_clk_enable;
  logic [3:0] next_vco_delay;
  logic next_dual;
  logic pll_active;

  assign pll_active = pll_source_sel && pll_circuit_en;

  always_comb
  begin
    next_recal_prev = regs[R_CAL][RECAL_BIT];
    // R07 edge of either sense
    next_recal_start = reset_n && (regs[R_CAL][RECAL_BIT] != recal_prev);
    // R08 R10 gated enable
    next_pll_clk_enable = reset_n && pll_active && regs[R_PHASE][PLL_EN_BIT];
    next_vco_delay = 4'h0;
    // R09 R10 R11 delay selection
    if (reset_n && pll_active && !decim_active)
      next_vco_delay = AOFPC_DLY_CYC[regs[R_PHASE][DLY_LSB +: DLY_W]];
    // R15 dual enable
    next_dual = reset_n && regs[R_DUAL][DUAL_BIT];
    if (!reset_n)
      next_recal_prev = AOFPC_RST[R_CAL][RECAL_BIT];
  end

  always_ff @(posedge sys_clk)
  begin
    recal_prev <= next_recal_prev;
    pll_recal_start <= next_recal_start;
    pll_clk_enable <= next_pll_clk_enable;
    out_clock_vco_delay <= next_vco_delay;
    dual_postproc_enable <= next_dual;
  end

  // ****************************************
  // Configuration crossing (toggle handshake)
  // ****************************************
  aofpc_cfg_t cfg_now;
  aofpc_cfg_t snap;
  aofpc_cfg_t next_snap;
  logic req;
  logic next_req;
  logic ack_s1;
  logic ack_s2;
  logic req_s3;

  always_comb
  begin
    cfg_now.offset = {regs[R_OFS_HI], regs[R_OFS_LO]};
    cfg_now.pat_a = {regs[R_PA_HI], regs[R_PA_LO]};
    cfg_now.pat_b = {regs[R_PB_HI], regs[R_PB_LO]};
    cfg_now.frame_inv = regs[R_FRAME][FRAME_INV_BIT];
    cfg_now.frame_en = regs[R_FRAME][FRAME_EN_BIT];
    cfg_now.xlsb_en = regs[R_FRAME][XLSB_EN_BIT];
    cfg_now.xlsb_inv = regs[R_FRAME][XLSB_INV_BIT];
    cfg_now.test_sel = test_pattern_sel;
    cfg_now.lvds = lvds_mode;
    cfg_now.res = res_mode;
    cfg_now.decim = decim_active;
  end

  // Snapshot frozen while a transfer is pending, so the far side sees a stable word
  always_comb
  begin
    next_snap = snap;
    next_req = req;
    if (!reset_n)
    begin
      next_snap = '0;
      next_req = 1'b0;
    end
    else if ((req == ack_s2) && (cfg_now != snap))
    begin
      next_snap = cfg_now;
      next_req = ~req;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    snap <= next_snap;
    req <= next_req;
    ack_s1 <= reset_n ? req_s3 : 1'b0;
    ack_s2 <= reset_n ? ack_s1 : 1'b0;
  end

  // ****************************************
  // Link domain
  // ****************************************
  logic rst_s1;
  logic link_rst_n;
  logic req_s1;
  logic req_s2;
  aofpc_cfg_t cfg_l;
  aofpc_cfg_t next_cfg_l;
  logic alt;
  logic next_alt;
  aofpc_link_out_t next_out;
  logic signed [SUM_W-1:0] ofs_ext;
  logic signed [SUM_W-1:0] sum;
  logic signed [SUM_W-1:0] sat;
  logic [15:0] pat;
  logic xlsb_on;
  logic [1:0] shamt;

  always_ff @(posedge link_clk)
  begin
    rst_s1 <= reset_n;
    link_rst_n <= rst_s1;
    req_s1 <= link_rst_n ? req : 1'b0;
    req_s2 <= link_rst_n ? req_s1 : 1'b0;
    req_s3 <= link_rst_n ? req_s2 : 1'b0;
  end

  always_comb
  begin
    next_cfg_l = cfg_l;
    if (!link_rst_n)
      next_cfg_l = '0;
    else if (req_s2 != req_s3)
      next_cfg_l = snap;
    next_alt = link_rst_n && !alt;
    // R02 step size by resolution
    shamt = RES_18 - cfg_l.res;
    // R01 signed global offset
    ofs_ext = SUM_W'(signed'(cfg_l.offset)) <<< shamt;
    sum = SUM_W'(conv_sample) + ofs_ext;
    // R19 saturate the sum
    if (sum > SAT_MAX)
      sat = SAT_MAX;
    else if (sum < SAT_MIN)
      sat = SAT_MIN;
    else
      sat = sum;
    // R17 alternate patterns
    pat = alt ? cfg_l.pat_b : cfg_l.pat_a;
    // R05 extra LSbs only for 16-bit decimated output
    xlsb_on = cfg_l.xlsb_en && (cfg_l.res == RES_16) && cfg_l.decim;
    next_out.data = sat[SAMPLE_W-1:2] & AOFPC_MASK[cfg_l.res];
    next_out.word_clock_out = {2{alt}};
    next_out.overrange_out = {2{conv_overrange || (sat != sum)}};
    next_out.extra_lsb_pin_one = xlsb_on ? {2{sat[1]}} : 2'h0;
    next_out.extra_lsb_pin_two = xlsb_on ? {2{sat[0]}} : 2'h0;
    next_out.lsb_oe = xlsb_on;
    if (cfg_l.test_sel == TP_DOUBLE)
    begin
      // Unused low pattern bits are ignored through the mask
      next_out.data = pat & AOFPC_MASK[cfg_l.res];
      // R18 pattern bits on aux pins
      next_out.overrange_out = cfg_l.pat_a[15:14];
      next_out.word_clock_out = cfg_l.pat_b[15:14];
      next_out.extra_lsb_pin_one = cfg_l.pat_a[1:0];
      next_out.extra_lsb_pin_two = cfg_l.pat_b[1:0];
      next_out.lsb_oe = 1'b1;
    end
    // R03 frame pair polarity
    if (cfg_l.lvds && cfg_l.frame_inv)
    begin
      next_out.word_clock_out = ~next_out.word_clock_out;
      next_out.overrange_out = ~next_out.overrange_out;
    end
    // R06 extra pair polarity
    if (cfg_l.lvds && cfg_l.xlsb_inv && next_out.lsb_oe)
    begin
      next_out.extra_lsb_pin_one = ~next_out.extra_lsb_pin_one;
      next_out.extra_lsb_pin_two = ~next_out.extra_lsb_pin_two;
    end
    // R04 frame pair enable
    next_out.frame_oe = cfg_l.frame_en;
    if (!cfg_l.frame_en)
    begin
      next_out.word_clock_out = 2'h0;
      next_out.overrange_out = 2'h0;
    end
    if (!link_rst_n)
      next_out = '0;
  end

  always_ff @(posedge link_clk)
  begin
    cfg_l <= next_cfg_l;
    alt <= next_alt;
    link_out <= next_out;
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_recal;
    @(posedge sys_clk) disable iff (!reset_n)
    $changed(regs[R_CAL][RECAL_BIT]) |=> pll_recal_start ##1 !pll_recal_start;
  endproperty
  a_recal: assert property (p_recal) else $error("recal pulse missing"); // R07

  property p_pll_gate;
    @(posedge sys_clk) disable iff (!reset_n)
    !(pll_source_sel && pll_circuit_en) |=> !pll_clk_enable && out_clock_vco_delay == 4'h0;
  endproperty
  a_pll_gate: assert property (p_pll_gate) else $error("PLL setting not gated"); // R10

  property p_pll_en;
    @(posedge sys_clk) disable iff (!reset_n)
    (pll_active && regs[R_PHASE][PLL_EN_BIT]) |=> pll_clk_enable;
  endproperty
  a_pll_en: assert property (p_pll_en) else $error("PLL clock not enabled"); // R08

  property p_dly15;
    @(posedge sys_clk) disable iff (!reset_n)
    (pll_active && !decim_active && regs[R_PHASE][DLY_LSB +: DLY_W] == 3'h7)
      |=> out_clock_vco_delay == 4'hf;
  endproperty
  a_dly15: assert property (p_dly15) else $error("delay code 7 not 15"); // R09

  property p_dly_decim;
    @(posedge sys_clk) disable iff (!reset_n)
    decim_active |=> out_clock_vco_delay == 4'h0;
  endproperty
  a_dly_decim: assert property (p_dly_decim) else $error("delay with decimation"); // R11

  property p_dual;
    @(posedge sys_clk) disable iff (!reset_n)
    ##1 dual_postproc_enable == $past(regs[R_DUAL][DUAL_BIT]);
  endproperty
  a_dual: assert property (p_dual) else $error("dual enable mismatch"); // R15

  property p_pat_rst;
    @(posedge sys_clk)
    !reset_n |=> {regs[R_PA_HI], regs[R_PA_LO]} == PAT_RST && {regs[R_PB_HI], regs[R_PB_LO]} == PAT_RST;
  endproperty
  a_pat_rst: assert property (p_pat_rst) else $error("pattern not reset"); // R13 R14

  property p_apb_ready;
    @(posedge sys_clk) disable iff (!reset_n)
    (psel && !penable) |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("pready timing"); // APB pready timing

  property p_frame_off;
    @(posedge link_clk) disable iff (!link_rst_n)
    !cfg_l.frame_en |=> !link_out.frame_oe && link_out.word_clock_out == 2'h0;
  endproperty
  a_frame_off: assert property (p_frame_off) else $error("frame pair driven"); // R04

  property p_ovr_pat;
    @(posedge link_clk) disable iff (!link_rst_n)
    (cfg_l.test_sel == TP_DOUBLE && !cfg_l.lvds && cfg_l.frame_en) ##1 $stable(cfg_l)
      |-> link_out.overrange_out == cfg_l.pat_a[15:14];
  endproperty
  a_ovr_pat: assert property (p_ovr_pat) else $error("overrange not pattern A"); // R18

  property p_clamp;
    @(posedge link_clk) disable iff (!link_rst_n)
    (cfg_l.test_sel != TP_DOUBLE && sum > SAT_MAX) |=> link_out.data[15] == 1'b0;
  endproperty
  a_clamp: assert property (p_clamp) else $error("sum wrapped"); // R19

  c_recal: cover property (@(posedge sys_clk) disable iff (!reset_n) pll_recal_start);
  c_write: cover property (@(posedge sys_clk) disable iff (!reset_n) wr_go && hit[R_OFS_HI]);
  c_double: cover property (@(posedge link_clk) disable iff (!link_rst_n)
    cfg_l.test_sel == TP_DOUBLE && alt);
  c_clamp: cover property (@(posedge link_clk) disable iff (!link_rst_n) sum < SAT_MIN);
endmodule : aofpc_top
`default_nettype wire

// ---- sim/aofpc_link_model.sv ----
// Link partner: feeds converter samples and captures the formatted output.
// Assumes link_clk runs free, as a converter clock does.
`timescale 1ns/1ps
`default_nettype none
module aofpc_link_model
  import aofpc_pkg::*;
(
  // Link clock
  input wire logic link_clk,
  // Sample requested by the bench
  input wire logic signed [aofpc_pkg::SAMPLE_W-1:0] sample_in,
  input wire logic ovr_in,
  // Converter side
  output logic signed [aofpc_pkg::SAMPLE_W-1:0] conv_sample,
  output logic conv_overrange,
  // Receiver side
  input wire aofpc_pkg::aofpc_link_out_t link_out,
  output aofpc_pkg::aofpc_link_out_t cap,
  output aofpc_pkg::aofpc_link_out_t prev
);
  // Two captures kept so alternation can be seen
  always_ff @(posedge link_clk)
  begin
    conv_sample <= sample_in;
    conv_overrange <= ovr_in;
    prev <= cap;
    cap <= link_out;
  end
endmodule : aofpc_link_model
`default_nettype wire

// ---- sim/tb_aofpc_top.sv ----
// Testbench: APB registers, PLL controls, offset path and double pattern.
// Assumes the link model drives samples and captures link_out.
`timescale 1ns/1ps
`default_nettype none
module tb_aofpc_top;
  import aofpc_pkg::*;
  logic sys_clk, link_clk, reset_n, psel, penable, pwrite, pready, pslverr, serr;
  logic [AOFPC_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, out_clock_vco_delay;
  logic pll_source_sel, pll_circuit_en, decim_active, lvds_mode, ovr_in, conv_overrange;
  logic pll_recal_start, pll_clk_enable, dual_postproc_enable;
  logic [1:0] res_mode;
  logic [2:0] test_pattern_sel;
  logic [17:0] s;
  logic signed [SAMPLE_W-1:0] conv_sample, sample_in;
  aofpc_link_out_t link_out, cap, prev;
  int err_count, n_compared, n_recal;
  logic [7:0] wv [4] = '{8'h01, 8'hc0, 8'h02, 8'h40};

  aofpc_top aofpc_top_i (.sys_clk(sys_clk), .reset_n(reset_n), .link_clk(link_clk),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pll_source_sel(pll_source_sel), .pll_circuit_en(pll_circuit_en),
    .decim_active(decim_active), .lvds_mode(lvds_mode), .res_mode(res_mode),
    .test_pattern_sel(test_pattern_sel), .pll_recal_start(pll_recal_start),
    .pll_clk_enable(pll_clk_enable), .out_clock_vco_delay(out_clock_vco_delay),
    .dual_postproc_enable(dual_postproc_enable), .conv_sample(conv_sample),
    .conv_overrange(conv_overrange), .link_out(link_out));

  aofpc_link_model aofpc_link_model_i (.link_clk(link_clk), .sample_in(sample_in),
    .ovr_in(ovr_in), .conv_sample(conv_sample), .conv_overrange(conv_overrange),
    .link_out(link_out), .cap(cap), .prev(prev));

  // ****************************************
  // Clocks; odd link phase avoids shared edges
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  always @(posedge sys_clk)
  begin
    if (pll_recal_start === 1'b1)
      n_recal++;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk("apb ready", 32'h1, {31'h0, pready});
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Config crosses to the link domain in a few cycles of each clock
  task automatic settle;
    repeat (40) @(posedge sys_clk);
  endtask : settle

  task automatic wait_data(input string what, input logic [15:0] exp);
    int n;
    n = 0;
    while (cap.data !== exp && n < 80)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(what, {16'h0, exp}, {16'h0, cap.data});
  endtask : wait_data

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  initial
  begin
    #100000;
    err_count++;
    $display("[ERR] watchdog expected done seen timeout");
    stop_test();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    pll_source_sel = 1'b0;
    pll_circuit_en = 1'b0;
    decim_active = 1'b0;
    lvds_mode = 1'b0;
    res_mode = RES_18;
    test_pattern_sel = 3'h0;
    sample_in = 18'h00100;
    ovr_in = 1'b0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < AOFPC_NREG; i++)
    begin
      apb(AOFPC_IDX[i], 1'b0, 8'h00);
      chk("reset value", {24'h0, AOFPC_RST[i]}, rd); // all register defaults
    end
    apb(8'h70, 1'b0, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, serr});
    for (int i = 0; i < 4; i++)
    begin
      apb(8'h74 + 8'(i), 1'b1, wv[i]); // low bits shown only at 16-bit and 18-bit
      apb(8'h74 + 8'(i), 1'b0, 8'h00);
      chk("pattern byte", {24'h0, wv[i]}, rd); // two bytes each
    end
    // Byte lane off: write must be dropped
    pstrb <= 4'he;
    apb(8'h74, 1'b1, 8'h55);
    pstrb <= 4'hf;
    apb(8'h74, 1'b0, 8'h00);
    chk("strobe off", {24'h0, wv[0]}, rd); // lane 0 gates write
    $display("test registers done");
    // Factory bits kept at reset while toggling
    n_recal = 0;
    apb(8'h6b, 1'b1, 8'h0c);
    apb(8'h6b, 1'b1, 8'h08);
    repeat (4) @(posedge sys_clk);
    chk("recal pulses", 32'h2, 32'(n_recal)); // both directions
    pll_source_sel <= 1'b1;
    pll_circuit_en <= 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      apb(8'h6d, 1'b1, {2'b00, 1'b1, 1'b0, 3'(c), 1'b0});
      repeat (3) @(posedge sys_clk);
      chk("vco delay", {28'h0, AOFPC_DLY_CYC[c]}, {28'h0, out_clock_vco_delay});
      chk("pll enable", 32'h1, {31'h0, pll_clk_enable});
    end
    pll_circuit_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("pll gated", 32'h0, {27'h0, pll_clk_enable, out_clock_vco_delay});
    pll_circuit_en <= 1'b1;
    decim_active <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("delay decim", 32'h10, {27'h0, pll_clk_enable, out_clock_vco_delay});
    decim_active <= 1'b0;
    apb(8'h79, 1'b1, 8'h80);
    repeat (3) @(posedge sys_clk);
    chk("dual on", 32'h1, {31'h0, dual_postproc_enable});
    $display("test pll controls done");
    apb(8'h66, 1'b1, 8'h10);
    for (int r = 0; r < 4; r++)
    begin
      res_mode <= 2'(r);
      s = 18'h00100 + (18'h10 << (3 - r));
      wait_data("offset sum", s[17:2] & AOFPC_MASK[r]); // step per mode
    end
    apb(8'h67, 1'b1, 8'h7f);
    apb(8'h66, 1'b1, 8'hff);
    sample_in <= 18'h1ff00;
    wait_data("clamp high", 16'h7fff);
    apb(8'h66, 1'b1, 8'h00);
    apb(8'h67, 1'b1, 8'h80);
    sample_in <= 18'h20000;
    wait_data("clamp low", 16'h8000); // no wrap
    $display("test offset done");
    test_pattern_sel <= TP_DOUBLE;
    // Let the stream settle so the previous capture is already pattern B
    settle();
    wait_data("pattern a", 16'hc001);
    chk("pattern b", 32'h4002, {16'h0, prev.data}); // alternation
    chk("ovr wck", 32'hd, {28'h0, cap.overrange_out, cap.word_clock_out});
    lvds_mode <= 1'b1;
    apb(8'h68, 1'b1, 8'h2d);
    settle();
    wait_data("pattern a inv", 16'hc001);
    chk("frame inverted", 32'h0, {30'h0, cap.overrange_out});
    chk("lsb inverted", 32'h2, {30'h0, cap.extra_lsb_pin_one});
    lvds_mode <= 1'b0;
    apb(8'h68, 1'b1, 8'h20);
    settle();
    chk("frame off", 32'h0, {27'h0, cap.frame_oe, cap.overrange_out, cap.word_clock_out});
    // Extra LSbs: 16-bit, decimated, offset 0x8000 at half-LSb steps
    test_pattern_sel <= 3'h0;
    res_mode <= RES_16;
    decim_active <= 1'b1;
    sample_in <= 18'h00102;
    apb(8'h68, 1'b1, 8'h26);
    settle();
    wait_data("extra lsb data", 16'hc040);
    chk("extra lsb pins", 32'h1c,
      {27'h0, cap.lsb_oe, cap.extra_lsb_pin_one, cap.extra_lsb_pin_two});
    $display("test pattern done");
    stop_test();
  end
endmodule : tb_aofpc_top
`default_nettype wire
